//--- verilog/solr_pkg.sv
`default_nettype none
package solr_pkg;
    // register offsets (word addresses on the plain port)
    localparam logic [3:0] LANE_CTL_ADDR = 4'h0;
    localparam logic [3:0] SYNTH_CTL_ADDR = 4'h4;

    // lane register field positions
    localparam int FAST_LINK_BIT = 20;
    localparam int MAC_OVR_BIT = 19;
    localparam int TX_PAUSE_BIT = 18;
    localparam int RX_PAUSE_BIT = 17;
    localparam int HS_SEL_BIT = 16;
    localparam int RX_PWR_OVR_BIT = 15;
    localparam int RX_PWR_LSB = 13;
    localparam int RX_SPD_OVR_BIT = 12;
    localparam int RX_SPD_LSB = 10;
    localparam int RX_INV_OVR_BIT = 9;
    localparam int RX_INV_BIT = 8;
    localparam int RX_COMMA_OVR_BIT = 7;
    localparam int RX_COMMA_BIT = 6;
    localparam int RX_WS_OVR_BIT = 5;
    localparam int RX_WS_LSB = 3;
    localparam int SLOW_LINK_BIT = 2;
    localparam int RX_FUNC_BIT = 1;
    localparam int RX_LOST_BIT = 0;

    // synth register field positions
    localparam int SA_OVR_BIT = 31;
    localparam int SA_PWR_LSB = 29;
    localparam int SA_READY_BIT = 28;
    localparam int SB_OVR_BIT = 27;
    localparam int SB_PWR_LSB = 25;
    localparam int SB_READY_BIT = 24;
    localparam int LN1_OK_BIT = 9;
    localparam int LN0_OK_BIT = 8;
    localparam int LN1_SD_BIT = 1;
    localparam int LN0_SD_BIT = 0;

    // reset value and unmapped read value
    localparam logic SB_OVR_RST = 1'b1;
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

    // power state encoding
    typedef enum logic [1:0]
    {
        SOLR_PWR_OFF,
        SOLR_PWR_SLEEP,
        SOLR_PWR_SNOOZE,
        SOLR_PWR_ON
    } solr_pwr_e;

    // receive lane configuration bundle
    typedef struct packed
    {
        logic [1:0] power;
        logic [1:0] speed;
        logic invert;
        logic comma_align;
        logic [1:0] word_size;
    } solr_rxcfg_s;

    // controls passed to the mac
    typedef struct packed
    {
        logic high_speed_select;
        logic tx_pause_capable;
        logic rx_pause_capable;
    } solr_mac_s;

    // live lane status inputs
    typedef struct packed
    {
        logic fast_link_up;
        logic slow_link_up;
        logic rx_lane_functional;
        logic rx_signal_lost;
        logic synth_a_ready;
        logic synth_b_ready;
        logic lane1_functional_live;
        logic lane0_functional_live;
        logic lane1_signal_present_live;
        logic lane0_signal_present_live;
    } solr_stat_s;

    // register state: software-writable fields, sampled status and read data
    typedef struct packed
    {
        logic mac_ctrl_override;
        solr_mac_s mac;
        logic rx_power_override;
        logic rx_speed_override;
        logic rx_invert_override;
        logic rx_comma_override;
        logic rx_word_size_override;
        solr_rxcfg_s rx;
        logic synth_a_power_override;
        logic [1:0] synth_a_power_state;
        logic synth_b_power_override;
        logic [1:0] synth_b_power_state;
        solr_stat_s stat;
        logic [31:0] rdata;
    } solr_state_s;
endpackage
`default_nettype wire

//--- verilog/solr_regs.sv
// ---------------------------------------------------------------
// Functional notes
// - bit 20 reports fast mac/pcs link up
// - bit 19 selects register over negotiated speed and pause
// - bit 18 tx pause capability, used only under override
// - bit 17 rx pause capability, used only under override
// - bit 16 picks 1g or 10g clock source, under override
// - bit 15 makes field 14-13 drive rx power state
// - bit 12 makes field 11-10 drive rx rate
// - bit 9 makes bit 8 drive rx polarity inversion
// - bit 7 makes bit 6 drive comma alignment
// - bit 5 makes field 4-3 drive rx word width
// - bit 2 reports slow mac/pcs link up
// - bit 1 reports rx lane functional
// - bit 0 reports rx signal loss or cdr unlock
// - bit 31 makes field 30-29 drive synth a power
// - bit 28 reports synth a ready
// - bit 27 makes field 26-25 drive synth b power
// - bit 24 reports synth b ready
// - synth bits 23-10 ignore writes and read zero
// - synth bits 9 and 8 show lane ok live
// - synth bits 1 and 0 show signal detect live
// ---------------------------------------------------------------
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module solr_regs
    import solr_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [3:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    input wire solr_stat_s stat_in,
    input wire solr_mac_s aneg_mac_in,
    input wire solr_rxcfg_s ext_rx_in,
    input wire logic [1:0] ext_synth_power_input_in,
    output solr_mac_s mac_out,
    output solr_rxcfg_s rx_cfg_out,
    output logic [1:0] synth_a_power_out,
    output logic [1:0] synth_b_power_out
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    solr_state_s st_r;
    solr_state_s st_nxt;
    solr_stat_s stat_meta_r;

    function automatic logic [1:0] pick2(input logic ovr,
                                         input logic [1:0] val,
                                         input logic [1:0] ext);
        pick2 = ovr ? val : ext;
    endfunction

    function automatic logic hits(input logic [3:0] a,
                                  input logic [3:0] reg_addr);
        hits = (a == reg_addr);
    endfunction

    function automatic logic [31:0] lane_word(input solr_state_s s);
        logic [31:0] w;
        w = '0;
        w[FAST_LINK_BIT] = s.stat.fast_link_up;
        w[MAC_OVR_BIT] = s.mac_ctrl_override;
        w[TX_PAUSE_BIT] = s.mac.tx_pause_capable;
        w[RX_PAUSE_BIT] = s.mac.rx_pause_capable;
        w[HS_SEL_BIT] = s.mac.high_speed_select;
        w[RX_PWR_OVR_BIT] = s.rx_power_override;
        w[RX_PWR_LSB +: 2] = s.rx.power;
        w[RX_SPD_OVR_BIT] = s.rx_speed_override;
        w[RX_SPD_LSB +: 2] = s.rx.speed;
        w[RX_INV_OVR_BIT] = s.rx_invert_override;
        w[RX_INV_BIT] = s.rx.invert;
        w[RX_COMMA_OVR_BIT] = s.rx_comma_override;
        w[RX_COMMA_BIT] = s.rx.comma_align;
        w[RX_WS_OVR_BIT] = s.rx_word_size_override;
        w[RX_WS_LSB +: 2] = s.rx.word_size;
        w[SLOW_LINK_BIT] = s.stat.slow_link_up;
        w[RX_FUNC_BIT] = s.stat.rx_lane_functional;
        w[RX_LOST_BIT] = s.stat.rx_signal_lost;
        lane_word = w;
    endfunction

    function automatic logic [31:0] synth_word(input solr_state_s s);
        logic [31:0] w;
        w = '0;
        w[SA_OVR_BIT] = s.synth_a_power_override;
        w[SA_PWR_LSB +: 2] = s.synth_a_power_state;
        w[SA_READY_BIT] = s.stat.synth_a_ready;
        w[SB_OVR_BIT] = s.synth_b_power_override;
        w[SB_PWR_LSB +: 2] = s.synth_b_power_state;
        w[SB_READY_BIT] = s.stat.synth_b_ready;
        w[LN1_OK_BIT] = s.stat.lane1_functional_live;
        w[LN0_OK_BIT] = s.stat.lane0_functional_live;
        w[LN1_SD_BIT] = s.stat.lane1_signal_present_live;
        w[LN0_SD_BIT] = s.stat.lane0_signal_present_live;
        synth_word = w;
    endfunction

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.stat = stat_meta_r;
        if (wr_in && hits(addr_in, LANE_CTL_ADDR))
        begin
            st_nxt.mac_ctrl_override = wdata_in[MAC_OVR_BIT];
            st_nxt.mac.tx_pause_capable = wdata_in[TX_PAUSE_BIT];
            st_nxt.mac.rx_pause_capable = wdata_in[RX_PAUSE_BIT];
            st_nxt.mac.high_speed_select = wdata_in[HS_SEL_BIT];
            st_nxt.rx_power_override = wdata_in[RX_PWR_OVR_BIT];
            st_nxt.rx.power = wdata_in[RX_PWR_LSB +: 2];
            st_nxt.rx_speed_override = wdata_in[RX_SPD_OVR_BIT];
            st_nxt.rx.speed = wdata_in[RX_SPD_LSB +: 2];
            st_nxt.rx_invert_override = wdata_in[RX_INV_OVR_BIT];
            st_nxt.rx.invert = wdata_in[RX_INV_BIT];
            st_nxt.rx_comma_override = wdata_in[RX_COMMA_OVR_BIT];
            st_nxt.rx.comma_align = wdata_in[RX_COMMA_BIT];
            st_nxt.rx_word_size_override = wdata_in[RX_WS_OVR_BIT];
            st_nxt.rx.word_size = wdata_in[RX_WS_LSB +: 2];
        end
        if (wr_in && hits(addr_in, SYNTH_CTL_ADDR))
        begin
            st_nxt.synth_a_power_override = wdata_in[SA_OVR_BIT];
            st_nxt.synth_a_power_state = wdata_in[SA_PWR_LSB +: 2];
            st_nxt.synth_b_power_override = wdata_in[SB_OVR_BIT];
            st_nxt.synth_b_power_state = wdata_in[SB_PWR_LSB +: 2];
        end
        st_nxt.rdata = RD_UNMAPPED;
        if (rd_in && hits(addr_in, LANE_CTL_ADDR))
            st_nxt.rdata = lane_word(st_r);
        else if (rd_in && hits(addr_in, SYNTH_CTL_ADDR))
            st_nxt.rdata = synth_word(st_r);
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        stat_meta_r <= stat_in;
        if (rst_in)
        begin
            st_r <= '0;
            st_r.synth_b_power_override <= SB_OVR_RST;
        end
        else
            st_r <= st_nxt;
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign rdata_out = st_r.rdata;

    always_comb
    begin
        mac_out = st_r.mac_ctrl_override ? st_r.mac : aneg_mac_in;
        rx_cfg_out.power = pick2(st_r.rx_power_override, st_r.rx.power,
                                 ext_rx_in.power);
        rx_cfg_out.speed = pick2(st_r.rx_speed_override, st_r.rx.speed,
                                 ext_rx_in.speed);
        rx_cfg_out.invert = st_r.rx_invert_override ? st_r.rx.invert
                                                    : ext_rx_in.invert;
        rx_cfg_out.comma_align = st_r.rx_comma_override
                                 ? st_r.rx.comma_align
                                 : ext_rx_in.comma_align;
        rx_cfg_out.word_size = pick2(st_r.rx_word_size_override,
                                     st_r.rx.word_size,
                                     ext_rx_in.word_size);
        synth_a_power_out = pick2(st_r.synth_a_power_override,
                                  st_r.synth_a_power_state,
                                  ext_synth_power_input_in);
        synth_b_power_out = pick2(st_r.synth_b_power_override,
                                  st_r.synth_b_power_state,
                                  ext_synth_power_input_in);
    end

endmodule // solr_regs
`default_nettype wire

//--- test/solr_far_model.sv
`timescale 1ns/100ps
`default_nettype none
module solr_far_model
    import solr_pkg::*;
(
    input wire logic clk_in,
    input wire logic upd_in,
    input wire logic [31:0] val_in,
    output solr_stat_s stat_out,
    output solr_mac_s aneg_out,
    output solr_rxcfg_s ext_rx_out,
    output logic [1:0] ext_pwr_out
);
    logic [22:0] v_r = 23'h0;
    // lane and synth side change config and status only when told
    always @(posedge clk_in)
    begin
        if (upd_in)
            v_r <= val_in[22:0];
    end
    assign stat_out = solr_stat_s'(v_r[9:0]);
    assign aneg_out = solr_mac_s'(v_r[12:10]);
    assign ext_rx_out = solr_rxcfg_s'(v_r[20:13]);
    assign ext_pwr_out = v_r[22:21];
endmodule // solr_far_model
`default_nettype wire

//--- test/solr_regs_properties.sv
`timescale 1ns/100ps
`default_nettype none
module solr_regs_checker
    import solr_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [3:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [31:0] rdata_out,
    input wire solr_stat_s stat_in,
    input wire solr_mac_s aneg_mac_in,
    input wire solr_rxcfg_s ext_rx_in,
    input wire logic [1:0] ext_synth_power_input_in,
    input wire solr_mac_s mac_out,
    input wire solr_rxcfg_s rx_cfg_out,
    input wire logic [1:0] synth_a_power_out,
    input wire logic [1:0] synth_b_power_out
);
    wire logic wl = wr_in && addr_in == LANE_CTL_ADDR;
    wire logic ws = wr_in && addr_in == SYNTH_CTL_ADDR;
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    property p_mac_pass;
        wl && !wdata_in[19] |=> mac_out == aneg_mac_in;
    endproperty
    a_mac_pass: assert property (p_mac_pass)
        else $error("mac pass");
    property p_mac_ovr;
        wl && wdata_in[19] |=> mac_out ==
            {$past(wdata_in[16]), $past(wdata_in[18]), $past(wdata_in[17])};
    endproperty
    a_mac_ovr: assert property (p_mac_ovr)
        else $error("mac override");
    property p_pwr;
        wl && wdata_in[15] ##1 !wr_in [*2]
            |-> rx_cfg_out.power == $past(wdata_in[14:13], 2);
    endproperty
    a_pwr: assert property (p_pwr)
        else $error("rx power");
    property p_inv;
        wl && wdata_in[9] |=> rx_cfg_out.invert == $past(wdata_in[8]);
    endproperty
    a_inv: assert property (p_inv)
        else $error("rx invert");
    property p_ws;
        wl && wdata_in[5] |=> rx_cfg_out.word_size == $past(wdata_in[4:3]);
    endproperty
    a_ws: assert property (p_ws)
        else $error("rx width");
    property p_sa;
        ws && wdata_in[31] |=> synth_a_power_out == $past(wdata_in[30:29]);
    endproperty
    a_sa: assert property (p_sa)
        else $error("synth a");
    property p_sb;
        ws && !wdata_in[27] |=> synth_b_power_out == ext_synth_power_input_in;
    endproperty
    a_sb: assert property (p_sb)
        else $error("synth b");
    property p_rsvd;
        rd_in && addr_in == SYNTH_CTL_ADDR |=> rdata_out[23:10] == 14'h0;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved bits");
    c_ovr: cover property (wl && wdata_in[19]);
    c_sb: cover property (ws && wdata_in[27]);
    c_rd: cover property (rd_in && addr_in == LANE_CTL_ADDR);
endmodule // solr_regs_checker
bind solr_regs solr_regs_checker solr_regs_checker_i (
    .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .stat_in(stat_in), .aneg_mac_in(aneg_mac_in),
    .ext_rx_in(ext_rx_in),
    .ext_synth_power_input_in(ext_synth_power_input_in),
    .mac_out(mac_out), .rx_cfg_out(rx_cfg_out),
    .synth_a_power_out(synth_a_power_out),
    .synth_b_power_out(synth_b_power_out));
`default_nettype wire

//--- test/tb_solr_regs.sv
`timescale 1ns/100ps
`default_nettype none
module tb_solr_regs
    import solr_pkg::*;
;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [3:0] addr_in = 4'h0;
    logic [31:0] wdata_in = 32'h0;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic upd = 1'b0;
    logic [31:0] val = 32'h0;
    logic [31:0] rdata_out;
    solr_stat_s stat;
    solr_mac_s aneg;
    solr_mac_s mac;
    solr_rxcfg_s ext_rx;
    solr_rxcfg_s rx;
    logic [1:0] ext_pwr;
    logic [1:0] sa;
    logic [1:0] sb;
    int mismatches = 0;
    int total_checks = 0;
    logic [31:0] v;
    logic [31:0] lane_m;
    logic [31:0] syn_m;
    logic [31:0] d;
    logic [3:0] ua;
    logic [31:0] e;
    logic rd_q = 1'b0;
    logic [31:0] exp_q[$];
    initial
    begin
        forever #50 clk_in = ~clk_in;
    end
    solr_far_model solr_far_model_i (.clk_in(clk_in), .upd_in(upd),
        .val_in(val), .stat_out(stat), .aneg_out(aneg),
        .ext_rx_out(ext_rx), .ext_pwr_out(ext_pwr));
    solr_regs solr_regs_i (.clk_in(clk_in), .rst_in(rst_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out), .stat_in(stat),
        .aneg_mac_in(aneg), .ext_rx_in(ext_rx),
        .ext_synth_power_input_in(ext_pwr), .mac_out(mac),
        .rx_cfg_out(rx), .synth_a_power_out(sa), .synth_b_power_out(sb));
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e)
        begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask
    task acc(input logic w, input logic r, input logic [3:0] a,
        input logic [31:0] dd);
        wr_in <= w;
        rd_in <= r;
        addr_in <= a;
        wdata_in <= dd;
        @(posedge clk_in);
    endtask
    task rd_chk(input logic [3:0] a, input logic [31:0] ex);
        exp_q.push_back(ex);
        acc(1'b0, 1'b1, a, 32'h0);
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task check_all;
        e = (lane_m & 32'h000F_FFF8) | {11'h0, v[9], 17'h0, v[8:6]};
        rd_chk(LANE_CTL_ADDR, e);
        e = (syn_m & 32'hEE00_0000) | {3'h0, v[5], 3'h0, v[4], 14'h0,
            v[3:2], 6'h0, v[1:0]};
        rd_chk(SYNTH_CTL_ADDR, e);
        e = {29'h0, lane_m[19] ? {lane_m[16], lane_m[18], lane_m[17]}
            : v[12:10]};
        chk("mac", {29'h0, mac}, e);
        e = {24'h0, lane_m[15] ? lane_m[14:13] : v[20:19],
            lane_m[12] ? lane_m[11:10] : v[18:17],
            lane_m[9] ? lane_m[8] : v[16], lane_m[7] ? lane_m[6] : v[15],
            lane_m[5] ? lane_m[4:3] : v[14:13]};
        chk("rx", {24'h0, rx}, e);
        e = {30'h0, syn_m[31] ? syn_m[30:29] : v[22:21]};
        chk("sa", {30'h0, sa}, e);
        e = {30'h0, syn_m[27] ? syn_m[26:25] : v[22:21]};
        chk("sb", {30'h0, sb}, e);
        acc(1'b0, 1'b0, 4'h0, 32'h0);
    endtask
    // read data checked mid-cycle: queued word after a read, else zero
    always @(posedge clk_in)
    begin
        rd_q <= rd_in;
    end
    always @(negedge clk_in)
    begin
        if (rd_q)
            chk("rdata", rdata_out, exp_q.pop_front());
        else
            chk("idle", rdata_out, 32'h0);
    end
    initial
    begin
        repeat (3000) @(posedge clk_in);
        mismatches++;
        final_report;
    end
    initial
    begin
        d = $urandom(1);
        v = $urandom;
        lane_m = 32'h0;
        syn_m = 32'h0800_0000;
        val <= v;
        upd <= 1'b1;
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        upd <= 1'b0;
        repeat (2) @(posedge clk_in);
        check_all;
        $display("test reset done");
        repeat (200)
        begin
            v = $urandom;
            d = $urandom;
            ua = 4'($urandom);
            if (ua == 4'h0 || ua == 4'h4)
                ua = 4'h8;
            val <= v;
            upd <= 1'b1;
            syn_m = d;
            acc(1'b1, 1'b0, SYNTH_CTL_ADDR, d);
            upd <= 1'b0;
            acc(1'b1, 1'b0, ua, $urandom);
            d = $urandom;
            lane_m = d;
            acc(1'b1, 1'b0, LANE_CTL_ADDR, d);
            rd_chk(ua, 32'h0);
            check_all;
        end
        $display("test random done");
        final_report;
    end
endmodule // tb_solr_regs
`default_nettype wire
